//--- hw/mpm_pkg.sv
package mpm_pkg;

   // Register byte offsets on the APB bus
   localparam logic [7:0] FLOPPY_CFG_OFS     = 8'h00;
   localparam logic [7:0] SERIAL_A_CFG_OFS   = 8'h04;
   localparam logic [7:0] SERIAL_B_CFG_OFS   = 8'h08;
   localparam logic [7:0] PARALLEL_CFG_OFS   = 8'h0c;
   localparam logic [7:0] STATUS_OFS         = 8'h10;

   // Field positions of the configuration registers; the delay field is floppy only
   localparam int CFG_APDN_BIT   = 0;
   localparam int CFG_DPDN_BIT   = 1;
   localparam int CFG_IDLE_BIT   = 2;
   localparam int CFG_RESET_BIT  = 3;
   localparam int CFG_DLY_LSB    = 4;

   // Data rate select write fields
   localparam int DSR_PDN_BIT    = 6;
   localparam int DSR_RESET_BIT  = 7;

   // Status register field positions
   localparam int ST_FDC_DIRECT  = 0;
   localparam int ST_FDC_SLEEP   = 1;
   localparam int ST_SER_TX_LSB  = 2;
   localparam int ST_SER_RX_LSB  = 4;
   localparam int ST_PAR_SLEEP   = 6;
   localparam int ST_PAR_DIRECT  = 7;

   // Values after reset and fixed comparison values
   localparam logic [1:0] DLY_SEL_RESET    = 2'h0;
   localparam logic [7:0] FDC_IDLE_MSR     = 8'h80;
   localparam logic [2:0] RX_IDLE_CHARS    = 3'h5;
   localparam logic [2:0] SYNC_RESET       = 3'h0;

   // Delay from floppy reset to polling interrupt
   localparam int CLK_PERIOD_NS   = 4;
   localparam int POLL_DELAY_NS   = 1000;
   localparam logic [11:0] POLL_CYCLES =
      12'((POLL_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

   // Floppy core signals seen by the power manager
   typedef struct packed {
      logic       access;       // Host touched output, status or FIFO register
      logic       dsr_wr;
      logic [7:0] dsr_data;
      logic       soft_rst;
      logic       apdn_cmd;     // Powerdown mode command executed
      logic [1:0] apdn_cmd_dly;
      logic [3:0] motor_enable_outputs;
      logic [7:0] floppy_main_status_reg;
      logic       floppy_interrupt_line;
      logic       head_unload_time_expired;
      logic       lock;
   } mpm_fdc_in_t;

   typedef struct packed {
      logic clk_en;
      logic status_clr;
      logic drive_init;
      logic fifo_default;
      logic poll_irq;
   } mpm_fdc_out_t;

   typedef struct packed {
      logic transmitter_empty_flag;
      logic tx_write;
      logic char_tick;
   } mpm_ser_in_t;

   typedef struct packed {
      logic tx_clk_en;
      logic rx_clk_en;
      logic sect_rst;
   } mpm_ser_out_t;

   typedef struct packed {
      logic fifo_used;
      logic fifo_empty;
      logic fifo_write;
      logic sm_idle;
   } mpm_par_in_t;

   typedef struct packed {
      logic clk_en;
      logic force_idle;
   } mpm_par_out_t;

endpackage

//--- hw/mpm_top.sv
`timescale 1ns/10ps
module mpm_top
   import mpm_pkg::*;
#(
   parameter logic [19:0] FDC_DLY_BASE = 20'h02000
)(
   // Clock and reset
   input  wire logic          CLK,
   input  wire logic          NRST,
   // APB slave
   input  wire logic          PSEL,
   input  wire logic          PENABLE,
   input  wire logic          PWRITE,
   input  wire logic [7:0]    PADDR,
   input  wire logic [31:0]   PWDATA,
   output logic      [31:0]   PRDATA,
   output logic               PREADY,
   output logic               PSLVERR,
   // Pins
   input  wire logic          HARDWARE_RESET_PIN,
   input  wire logic [1:0]    SERIAL_INPUT_LINE,
   input  wire logic          PARALLEL_LINE,
   // Module cores
   input  wire mpm_fdc_in_t   FDC_IN,
   input  wire mpm_ser_in_t   SER_A_IN,
   input  wire mpm_ser_in_t   SER_B_IN,
   input  wire mpm_par_in_t   PAR_IN,
   output mpm_fdc_out_t       FDC_OUT,
   output mpm_ser_out_t       SER_A_OUT,
   output mpm_ser_out_t       SER_B_OUT,
   output mpm_par_out_t       PAR_OUT
);

   typedef struct packed {
      logic [2:0]          hw_sync;
      logic [1:0][2:0]     sin_sync;
      logic [2:0]          par_sync;
      logic                hw_level;
      logic [1:0]          sin_level;
      logic                par_level;
      logic                f_cfg_apdn;
      logic                f_cfg_dpdn;
      logic [1:0]          f_dly;
      logic                f_cmd_mode;
      logic                f_dsr_pd;
      logic                f_direct;
      logic                f_sleep;
      logic [19:0]         f_timer;
      logic [11:0]         poll_cnt;
      logic [1:0]          s_apdn;
      logic [1:0]          s_dpdn;
      logic [1:0][2:0]     s_rx_cnt;
      logic [1:0]          s_rx_sleep;
      logic                p_apdn;
      logic                p_dpdn;
      logic                p_sleep;
      logic [31:0]         prdata;
      logic                pready;
      logic                pslverr;
      mpm_fdc_out_t        fdc;
      mpm_ser_out_t [1:0]  ser;
      mpm_par_out_t        par;
   } mpm_state_t;

   localparam mpm_state_t STATE_RESET = '{
      hw_sync:   SYNC_RESET,
      sin_sync:  {2{3'h7}},
      par_sync:  SYNC_RESET,
      sin_level: 2'h3,
      f_dly:     DLY_SEL_RESET,
      fdc:       5'h10,
      ser:       {2{3'h6}},
      par:       2'h2,
      default:   '0
   };

   mpm_state_t state;
   mpm_state_t next_state;

   // Register offset match used by every decode
   function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
      hit = (addr == ofs);
   endfunction

   // Config word layout shared by all four registers
   function automatic logic [31:0] cfg_word(input logic apdn, input logic dpdn,
                                            input logic idle);
      cfg_word = '0;
      cfg_word[CFG_APDN_BIT] = apdn;
      cfg_word[CFG_DPDN_BIT] = dpdn;
      cfg_word[CFG_IDLE_BIT] = idle;
   endfunction

   logic          wr_now;
   logic          f_any_rst;
   logic          f_hard_rst;
   logic          f_idle;
   logic          f_mode;
   logic          f_req_direct;
   logic [19:0]   f_limit;
   logic [1:0]    s_idle;
   logic          p_idle;
   logic          p_wake;
   mpm_ser_in_t [1:0] ser_in;

   assign ser_in = {SER_B_IN, SER_A_IN};

   // Next-state logic for the whole block
   always_comb begin
      logic [1:0] sin_act;
      logic [1:0] s_rst;
      logic       p_rst;
      logic [7:0] ofs;
      sin_act    = '0;
      s_rst      = '0;
      p_rst      = 1'b0;
      ofs        = 8'h00;
      next_state = state;

      // Pins pass three flops; a level counts once flops two and three agree
      next_state.hw_sync  = {state.hw_sync[1:0], HARDWARE_RESET_PIN};
      next_state.par_sync = {state.par_sync[1:0], PARALLEL_LINE};
      for (int i = 0; i < 2; i++) begin
         next_state.sin_sync[i] = {state.sin_sync[i][1:0], SERIAL_INPUT_LINE[i]};
         if (state.sin_sync[i][1] == state.sin_sync[i][2]) begin
            next_state.sin_level[i] = state.sin_sync[i][2];
         end
         sin_act[i] = next_state.sin_level[i] != state.sin_level[i];
         s_idle[i] = ser_in[i].transmitter_empty_flag && state.s_rx_cnt[i] >= RX_IDLE_CHARS;
      end
      if (state.hw_sync[1] == state.hw_sync[2]) begin
         next_state.hw_level = state.hw_sync[2];
      end
      if (state.par_sync[1] == state.par_sync[2]) begin
         next_state.par_level = state.par_sync[2];
      end

      // Idle needs motors off, status 80h, no interrupt, head unloaded
      f_idle  = (FDC_IN.motor_enable_outputs == 4'h0) &&
                (FDC_IN.floppy_main_status_reg == FDC_IDLE_MSR) &&
                !FDC_IN.floppy_interrupt_line && FDC_IN.head_unload_time_expired;
      // With the FIFO in use, idle also needs it empty
      p_idle = PAR_IN.sm_idle && (!PAR_IN.fifo_used || PAR_IN.fifo_empty);

      // APB: answer one cycle after setup, no wait states
      wr_now = PSEL && PENABLE && state.pready && PWRITE;
      next_state.pready  = PSEL && !PENABLE;
      next_state.pslverr = 1'b0;
      if (PSEL && !PENABLE) begin
         ofs = PADDR;
         next_state.pslverr = !(hit(ofs, FLOPPY_CFG_OFS) || hit(ofs, SERIAL_A_CFG_OFS) ||
                                hit(ofs, SERIAL_B_CFG_OFS) || hit(ofs, PARALLEL_CFG_OFS) ||
                                hit(ofs, STATUS_OFS));
      end

      // Read data captured in the setup cycle; idle bits are live state
      next_state.prdata = '0;
      if (PSEL && !PENABLE && !PWRITE) begin
         if (hit(PADDR, FLOPPY_CFG_OFS)) begin
            next_state.prdata = cfg_word(state.f_cfg_apdn, state.f_cfg_dpdn, f_idle);
            next_state.prdata[CFG_DLY_LSB +: 2] = state.f_dly;
         end
         if (hit(PADDR, SERIAL_A_CFG_OFS)) begin
            next_state.prdata = cfg_word(state.s_apdn[0], state.s_dpdn[0], s_idle[0]);
         end
         if (hit(PADDR, SERIAL_B_CFG_OFS)) begin
            next_state.prdata = cfg_word(state.s_apdn[1], state.s_dpdn[1], s_idle[1]);
         end
         if (hit(PADDR, PARALLEL_CFG_OFS)) begin
            next_state.prdata = cfg_word(state.p_apdn, state.p_dpdn, p_idle);
         end
         if (hit(PADDR, STATUS_OFS)) begin
            next_state.prdata[ST_FDC_DIRECT] = state.f_direct;
            next_state.prdata[ST_FDC_SLEEP]  = state.f_sleep;
            next_state.prdata[ST_SER_TX_LSB +: 2] = {!state.ser[1].tx_clk_en,
                                                     !state.ser[0].tx_clk_en};
            next_state.prdata[ST_SER_RX_LSB +: 2] = state.s_rx_sleep;
            next_state.prdata[ST_PAR_SLEEP]  = state.p_sleep;
            next_state.prdata[ST_PAR_DIRECT] = state.p_dpdn;
         end
      end

      // ---------------- Floppy ----------------
      f_hard_rst = state.hw_level;
      f_any_rst  = f_hard_rst || FDC_IN.soft_rst ||
                   (FDC_IN.dsr_wr && FDC_IN.dsr_data[DSR_RESET_BIT]) ||
                   (wr_now && hit(PADDR, FLOPPY_CFG_OFS) && PWDATA[CFG_RESET_BIT]);
      if (wr_now && hit(PADDR, FLOPPY_CFG_OFS)) begin
         next_state.f_cfg_apdn = PWDATA[CFG_APDN_BIT];
         next_state.f_cfg_dpdn = PWDATA[CFG_DPDN_BIT];
         next_state.f_dly      = PWDATA[CFG_DLY_LSB +: 2];
      end
      if (FDC_IN.apdn_cmd) begin
         next_state.f_cmd_mode = 1'b1;
         next_state.f_dly      = FDC_IN.apdn_cmd_dly;
      end
      if (FDC_IN.dsr_wr) begin
         next_state.f_dsr_pd = FDC_IN.dsr_data[DSR_PDN_BIT];
      end
      // Only hard and rate-select resets disarm auto mode; soft reset keeps it
      if (f_hard_rst || (FDC_IN.dsr_wr && FDC_IN.dsr_data[DSR_RESET_BIT])) begin
         next_state.f_cmd_mode = 1'b0;
         next_state.f_cfg_apdn = 1'b0;
      end
      if (f_hard_rst) begin
         next_state.f_cfg_dpdn = 1'b0;
         next_state.f_dsr_pd   = 1'b0;
         next_state.f_dly      = DLY_SEL_RESET;
      end

      f_req_direct = next_state.f_dsr_pd || next_state.f_cfg_dpdn;
      next_state.fdc.status_clr = 1'b0;
      if (f_req_direct && !state.f_direct) begin
         next_state.f_direct       = 1'b1;
         next_state.fdc.status_clr = 1'b1;
      end else if (state.f_direct && f_any_rst && !f_req_direct) begin
         next_state.f_direct = 1'b0;
      end

      f_mode  = state.f_cmd_mode || state.f_cfg_apdn;
      f_limit = FDC_DLY_BASE << state.f_dly;
      // Soft reset restarts the delay timer but leaves the mode armed
      if (!f_mode || !f_idle || FDC_IN.access || f_any_rst) begin
         next_state.f_timer = '0;
      end else if (state.f_timer < f_limit) begin
         next_state.f_timer = state.f_timer + 20'h00001;
      end
      if (FDC_IN.access || f_any_rst || !f_mode) begin
         next_state.f_sleep = 1'b0;
      end else if (f_idle && state.f_timer >= f_limit) begin
         next_state.f_sleep = 1'b1;
      end
      next_state.fdc.clk_en = !next_state.f_direct && !next_state.f_sleep;

      // Post-reset sequence, polling interrupt after a fixed delay
      next_state.fdc.drive_init   = f_any_rst;
      next_state.fdc.fifo_default = f_any_rst && !FDC_IN.lock;
      next_state.fdc.poll_irq     = 1'b0;
      if (f_any_rst) begin
         next_state.poll_cnt = POLL_CYCLES;
      end else if (state.poll_cnt != 12'h000) begin
         next_state.poll_cnt = state.poll_cnt - 12'h001;
         next_state.fdc.poll_irq = (state.poll_cnt == 12'h001);
      end

      // ---------------- Serial ports ----------------
      for (int i = 0; i < 2; i++) begin
         ofs = (i == 0) ? SERIAL_A_CFG_OFS : SERIAL_B_CFG_OFS;
         s_rst[i] = state.hw_level ||
                    (wr_now && hit(PADDR, ofs) && PWDATA[CFG_RESET_BIT]);
         if (wr_now && hit(PADDR, ofs)) begin
            next_state.s_apdn[i] = PWDATA[CFG_APDN_BIT];
            next_state.s_dpdn[i] = PWDATA[CFG_DPDN_BIT];
         end
         if (s_rst[i]) begin
            next_state.s_apdn[i] = 1'b0;
            next_state.s_dpdn[i] = 1'b0;
         end
         // Section reset only on the rising edge of the direct bit
         next_state.ser[i].sect_rst = next_state.s_dpdn[i] && !state.s_dpdn[i];

         // Receiver idle counter in character ticks; any line change wakes it
         if (sin_act[i] || !state.s_apdn[i]) begin
            next_state.s_rx_cnt[i]   = '0;
            next_state.s_rx_sleep[i] = 1'b0;
         end else if (ser_in[i].char_tick && state.s_rx_cnt[i] < RX_IDLE_CHARS) begin
            next_state.s_rx_cnt[i] = state.s_rx_cnt[i] + 3'h1;
         end else if (state.s_rx_cnt[i] >= RX_IDLE_CHARS) begin
            next_state.s_rx_sleep[i] = 1'b1;
         end

         // In auto mode the transmitter is gated while empty; a write ungates it at once
         next_state.ser[i].tx_clk_en = !next_state.s_dpdn[i] &&
            !(next_state.s_apdn[i] && ser_in[i].transmitter_empty_flag &&
              !ser_in[i].tx_write);
         next_state.ser[i].rx_clk_en = !next_state.s_dpdn[i] &&
                                       !next_state.s_rx_sleep[i];
      end

      // ---------------- Parallel port ----------------
      p_rst = state.hw_level ||
              (wr_now && hit(PADDR, PARALLEL_CFG_OFS) && PWDATA[CFG_RESET_BIT]);
      if (wr_now && hit(PADDR, PARALLEL_CFG_OFS)) begin
         next_state.p_apdn = PWDATA[CFG_APDN_BIT];
         next_state.p_dpdn = PWDATA[CFG_DPDN_BIT];
      end
      if (p_rst) begin
         next_state.p_apdn = 1'b0;
         next_state.p_dpdn = 1'b0;
      end
      p_wake = PAR_IN.fifo_write || (next_state.par_level != state.par_level);
      if (p_wake || !state.p_apdn || p_rst) begin
         next_state.p_sleep = 1'b0;
      end else if (p_idle) begin
         next_state.p_sleep = 1'b1;
      end
      next_state.par.clk_en     = !next_state.p_dpdn && !next_state.p_sleep;
      next_state.par.force_idle = next_state.p_dpdn;

      next_state.prdata  = next_state.pready ? next_state.prdata : 32'h00000000;
   end

   // Every enable leaves a flop; the core's latch-based gate then cannot glitch
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         state <= STATE_RESET;
      end else begin
         state <= next_state;
      end
   end

   // Outputs straight from the state register
   assign PRDATA    = state.prdata;
   assign PREADY    = state.pready;
   assign PSLVERR   = state.pslverr;
   assign FDC_OUT   = state.fdc;
   assign SER_A_OUT = state.ser[0];
   assign SER_B_OUT = state.ser[1];
   assign PAR_OUT   = state.par;

endmodule

//--- testbench/mpm_props.sv
`timescale 1ns/10ps
module mpm_props
   import mpm_pkg::*;
#(
   parameter logic [19:0] FDC_DLY_BASE = 20'h02000
)(
   // Clock and reset
   input wire logic         CLK,
   input wire logic         NRST,
   // APB
   input wire logic         PSEL,
   input wire logic         PENABLE,
   input wire logic         PWRITE,
   input wire logic [7:0]   PADDR,
   input wire logic [31:0]  PWDATA,
   input wire logic [31:0]  PRDATA,
   input wire logic         PREADY,
   input wire logic         PSLVERR,
   // Pins
   input wire logic         HARDWARE_RESET_PIN,
   input wire logic [1:0]   SERIAL_INPUT_LINE,
   input wire logic         PARALLEL_LINE,
   // Module cores
   input wire mpm_fdc_in_t  FDC_IN,
   input wire mpm_ser_in_t  SER_A_IN,
   input wire mpm_ser_in_t  SER_B_IN,
   input wire mpm_par_in_t  PAR_IN,
   input wire mpm_fdc_out_t FDC_OUT,
   input wire mpm_ser_out_t SER_A_OUT,
   input wire mpm_ser_out_t SER_B_OUT,
   input wire mpm_par_out_t PAR_OUT
);
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!NRST);

   logic [11:0] pcnt;
   logic        fdc_idle_q;
   logic        par_idle_q;

   // Cycles since the last floppy reset, saturating so it never wraps
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         pcnt       <= 12'h000;
         fdc_idle_q <= 1'b0;
         par_idle_q <= 1'b0;
      end else begin
         pcnt       <= FDC_OUT.drive_init ? 12'h000 : pcnt + {11'h000, pcnt != 12'hfff};
         fdc_idle_q <= FDC_IN.motor_enable_outputs == 4'h0 && !FDC_IN.floppy_interrupt_line
                       && FDC_IN.floppy_main_status_reg == FDC_IDLE_MSR
                       && FDC_IN.head_unload_time_expired;
         par_idle_q <= PAR_IN.sm_idle && (!PAR_IN.fifo_used || PAR_IN.fifo_empty);
      end
   end

   AST_PREADY: assert property (PSEL && !PENABLE |=> PREADY)
      else $error("ready missing after setup");
   AST_PRD_IDLE: assert property (!PREADY |-> PRDATA == 32'h0 && !PSLVERR)
      else $error("read data or error outside access");
   AST_DSR_PDN: assert property (FDC_IN.dsr_wr && FDC_IN.dsr_data[DSR_PDN_BIT]
      |-> ##[1:3] !FDC_OUT.clk_en) else $error("rate select powerdown ignored");
   AST_CFG_PDN: assert property (PSEL && PENABLE && PREADY && PWRITE
      && PADDR == FLOPPY_CFG_OFS && PWDATA[CFG_DPDN_BIT] && !PWDATA[CFG_RESET_BIT]
      |-> ##[1:3] !FDC_OUT.clk_en) else $error("floppy direct powerdown ignored");
   AST_STCLR: assert property (FDC_OUT.status_clr |-> ##[0:2] !FDC_OUT.clk_en)
      else $error("status cleared without powerdown");
   AST_POLL: assert property (FDC_OUT.poll_irq |-> pcnt >= 12'h0f0 && pcnt <= 12'h104)
      else $error("polling interrupt off its delay");
   AST_FDC_SLEEP: assert property ($fell(FDC_OUT.clk_en) && !$past(FDC_OUT.status_clr)
      |-> fdc_idle_q or ##[0:1] FDC_OUT.status_clr) else $error("floppy slept while busy");
   AST_SECT_RST: assert property (SER_A_OUT.sect_rst
      |-> ##[0:2] !SER_A_OUT.tx_clk_en && !SER_A_OUT.rx_clk_en)
      else $error("serial reset without clock stop");
   AST_PAR_IDLE: assert property (PAR_OUT.force_idle |-> !PAR_OUT.clk_en)
      else $error("parallel forced idle with clock on");
   AST_PAR_SLEEP: assert property ($fell(PAR_OUT.clk_en) && !PAR_OUT.force_idle
      |-> par_idle_q) else $error("parallel slept while busy");

   // Main scenarios reached
   COV_POLL: cover property (FDC_OUT.poll_irq);
   COV_RX_SLEEP: cover property ($fell(SER_A_OUT.rx_clk_en));
   COV_SLVERR: cover property (PSLVERR);
endmodule

bind mpm_top mpm_props #(.FDC_DLY_BASE(FDC_DLY_BASE)) u_props (
   .CLK(CLK), .NRST(NRST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
   .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
   .HARDWARE_RESET_PIN(HARDWARE_RESET_PIN), .SERIAL_INPUT_LINE(SERIAL_INPUT_LINE),
   .PARALLEL_LINE(PARALLEL_LINE), .FDC_IN(FDC_IN), .SER_A_IN(SER_A_IN),
   .SER_B_IN(SER_B_IN), .PAR_IN(PAR_IN), .FDC_OUT(FDC_OUT), .SER_A_OUT(SER_A_OUT),
   .SER_B_OUT(SER_B_OUT), .PAR_OUT(PAR_OUT)
);

//--- testbench/mpm_tb_top.sv
`timescale 1ns/10ps
module mpm_tb_top
   import mpm_pkg::*;
   ;
   // Short floppy delay keeps the run brief
   localparam logic [19:0] DLY = 20'h00010;
   logic         clk, nrst, psel, penable, pwrite, pready, pslverr, hrst, pline, e, di, fd;
   logic [7:0]   paddr;
   logic [31:0]  pwdata, prdata, r;
   logic [1:0]   sline;
   mpm_fdc_in_t  fi;
   mpm_ser_in_t  sa, sb;
   mpm_par_in_t  pi;
   mpm_fdc_out_t fo;
   mpm_ser_out_t soa, sob;
   mpm_par_out_t po;
   int           mismatches, n_checks, k;

   mpm_top #(.FDC_DLY_BASE(DLY)) DUT (
      .CLK(clk), .NRST(nrst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
      .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .HARDWARE_RESET_PIN(hrst), .SERIAL_INPUT_LINE(sline), .PARALLEL_LINE(pline),
      .FDC_IN(fi), .SER_A_IN(sa), .SER_B_IN(sb), .PAR_IN(pi),
      .FDC_OUT(fo), .SER_A_OUT(soa), .SER_B_OUT(sob), .PAR_OUT(po)
   );

   // Free-running clock, 4 ns period
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   task close_out;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task c1(input logic g, input logic x, input string m);
      n_checks++;
      if (g !== x) begin
         mismatches++;
         $display("mismatch at %0t: %s", $time, m);
      end
   endtask

   task c32(input logic [31:0] g, input logic [31:0] x, input string m);
      n_checks++;
      if (g !== x) begin
         mismatches++;
         $display("mismatch at %0t: %s", $time, m);
      end
   endtask

   // One APB transfer; waits for ready instead of assuming zero wait
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int i;
      @(posedge clk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      i = 0;
      do begin @(posedge clk); i++; end while (pready !== 1'b1 && i < 20);
      c1(pready, 1'b1, "no ready");
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // Read and compare under a mask; error expected beyond the status word
   task rd(input logic [7:0] a, input logic [31:0] x, input logic [31:0] m);
      apb(1'b0, a, 32'h0);
      c32(r & m, x, "read data");
      c1(e, a > STATUS_OFS, "slave error");
   endtask

   task t_regs;
      rd(FLOPPY_CFG_OFS, 32'h0, 32'hfffffffb);
      rd(8'h14, 32'h0, 32'hffffffff);
      apb(1'b1, STATUS_OFS, 32'h000000ff);
      rd(STATUS_OFS, 32'h0, 32'h000000ff);
      apb(1'b1, SERIAL_A_CFG_OFS, 32'h00000004);
      rd(SERIAL_A_CFG_OFS, 32'h0, 32'h0000000f);
   endtask

   task t_fdc_auto;
      @(posedge clk) fi.motor_enable_outputs <= 4'h1;
      apb(1'b1, FLOPPY_CFG_OFS, 32'h00000001);
      repeat (60) @(negedge clk);
      c1(fo.clk_en, 1'b1, "slept with motor on");
      @(posedge clk) fi.motor_enable_outputs <= 4'h0;
      for (k = 0; k < 100 && fo.clk_en !== 1'b0; k++) @(negedge clk);
      c1(fo.clk_en, 1'b0, "no auto sleep");
      c1(k >= DLY, 1'b1, "slept before delay");
      @(posedge clk) fi.access <= 1'b1;
      @(posedge clk) fi.access <= 1'b0;
      for (k = 0; k < 5 && fo.clk_en !== 1'b1; k++) @(negedge clk);
      c1(fo.clk_en, 1'b1, "no wake on access");
      for (k = 0; k < 100 && fo.clk_en !== 1'b0; k++) @(negedge clk);
      @(posedge clk) fi.soft_rst <= 1'b1;
      @(posedge clk) fi.soft_rst <= 1'b0;
      for (k = 0; k < 5 && fo.clk_en !== 1'b1; k++) @(negedge clk);
      c1(fo.clk_en, 1'b1, "no wake on reset");
      for (k = 0; k < 100 && fo.clk_en !== 1'b0; k++) @(negedge clk);
      c1(fo.clk_en, 1'b0, "auto lost on soft reset");
      @(posedge clk) begin fi.dsr_wr <= 1'b1; fi.dsr_data <= 8'h80; end
      @(posedge clk) fi.dsr_wr <= 1'b0;
      repeat (60) @(negedge clk);
      c1(fo.clk_en, 1'b1, "auto kept after rate reset");
   endtask

   task t_fdc_dir;
      apb(1'b1, FLOPPY_CFG_OFS, 32'h00000003);
      for (k = 0; k < 6 && fo.status_clr !== 1'b1; k++) @(negedge clk);
      c1(fo.status_clr, 1'b1, "no status clear");
      @(negedge clk) c1(fo.clk_en, 1'b0, "direct clock on");
      rd(STATUS_OFS, 32'h1, 32'h1);
      @(posedge clk) fi.access <= 1'b1;
      @(posedge clk) fi.access <= 1'b0;
      repeat (5) @(negedge clk);
      c1(fo.clk_en, 1'b0, "access woke direct");
      apb(1'b1, FLOPPY_CFG_OFS, 32'h0);
      repeat (20) @(negedge clk);
      c1(fo.clk_en, 1'b0, "left direct without reset");
      @(posedge clk) fi.soft_rst <= 1'b1;
      @(posedge clk) fi.soft_rst <= 1'b0;
      di = 1'b0;
      fd = 1'b0;
      repeat (8) @(negedge clk) begin di |= fo.drive_init; fd |= fo.fifo_default; end
      c1(di, 1'b1, "no drive init");
      c1(fd, 1'b1, "no fifo default");
      c1(fo.clk_en, 1'b1, "no exit on reset");
      for (k = 0; k < 300 && fo.poll_irq !== 1'b1; k++) @(negedge clk);
      c1(fo.poll_irq, 1'b1, "no poll");
      c1(k > 230, 1'b1, "poll early");
      @(posedge clk) begin fi.lock <= 1'b1; fi.dsr_wr <= 1'b1; fi.dsr_data <= 8'h40; end
      @(posedge clk) fi.dsr_wr <= 1'b0;
      repeat (4) @(negedge clk);
      c1(fo.clk_en, 1'b0, "rate powerdown ignored");
      @(posedge clk) begin fi.dsr_wr <= 1'b1; fi.dsr_data <= 8'h80; end
      @(posedge clk) fi.dsr_wr <= 1'b0;
      fd = 1'b0;
      repeat (8) @(negedge clk) fd |= fo.fifo_default;
      c1(fd, 1'b0, "fifo default under lock");
      c1(fo.clk_en, 1'b1, "no exit on rate reset");
   endtask

   task t_ser;
      apb(1'b1, SERIAL_A_CFG_OFS, 32'h00000001);
      for (k = 0; k < 6 && soa.tx_clk_en !== 1'b0; k++) @(negedge clk);
      c1(soa.tx_clk_en, 1'b0, "tx not gated");
      rd(SERIAL_A_CFG_OFS, 32'h1, 32'h0000000b);
      @(posedge clk) begin sa.tx_write <= 1'b1; sa.transmitter_empty_flag <= 1'b0; end
      @(posedge clk) sa.tx_write <= 1'b0;
      @(negedge clk) c1(soa.tx_clk_en, 1'b1, "no tx wake");
      for (k = 0; k < 5; k++) begin
         if (k == 4) c1(soa.rx_clk_en, 1'b1, "rx slept early");
         @(posedge clk) sa.char_tick <= 1'b1;
         @(posedge clk) sa.char_tick <= 1'b0;
      end
      for (k = 0; k < 4 && soa.rx_clk_en !== 1'b0; k++) @(negedge clk);
      c1(soa.rx_clk_en, 1'b0, "rx awake");
      @(posedge clk) sa.transmitter_empty_flag <= 1'b1;
      repeat (3) @(negedge clk);
      rd(SERIAL_A_CFG_OFS, 32'h5, 32'h0000000f);
      @(posedge clk) sline[0] <= 1'b0;
      for (k = 0; k < 8 && soa.rx_clk_en !== 1'b1; k++) @(negedge clk);
      c1(soa.rx_clk_en, 1'b1, "no rx wake");
      apb(1'b1, SERIAL_A_CFG_OFS, 32'h00000002);
      for (k = 0; k < 6 && soa.sect_rst !== 1'b1; k++) @(negedge clk);
      c1(soa.sect_rst, 1'b1, "no section reset");
      repeat (2) @(negedge clk);
      c1(soa.tx_clk_en | soa.rx_clk_en, 1'b0, "direct clock on");
      rd(SERIAL_A_CFG_OFS, 32'h2, 32'h0000000b);
      apb(1'b1, SERIAL_A_CFG_OFS, 32'h0);
      for (k = 0; k < 6 && soa.tx_clk_en !== 1'b1; k++) @(negedge clk);
      c1(soa.tx_clk_en, 1'b1, "no exit on clear");
      apb(1'b1, SERIAL_B_CFG_OFS, 32'h00000002);
      apb(1'b1, SERIAL_B_CFG_OFS, 32'h00000008);
      for (k = 0; k < 6 && sob.tx_clk_en !== 1'b1; k++) @(negedge clk);
      c1(sob.tx_clk_en, 1'b1, "no exit on reset bit");
   endtask

   task t_par;
      @(posedge clk) begin pi.fifo_used <= 1'b1; pi.fifo_empty <= 1'b0; end
      apb(1'b1, PARALLEL_CFG_OFS, 32'h00000001);
      repeat (20) @(negedge clk);
      c1(po.clk_en, 1'b1, "slept with fifo data");
      @(posedge clk) pi.fifo_empty <= 1'b1;
      for (k = 0; k < 8 && po.clk_en !== 1'b0; k++) @(negedge clk);
      c1(po.clk_en, 1'b0, "no parallel sleep");
      @(posedge clk) pi.fifo_write <= 1'b1;
      @(posedge clk) pi.fifo_write <= 1'b0;
      for (k = 0; k < 6 && po.clk_en !== 1'b1; k++) @(negedge clk);
      c1(po.clk_en, 1'b1, "no wake on fifo write");
      for (k = 0; k < 8 && po.clk_en !== 1'b0; k++) @(negedge clk);
      @(posedge clk) pline <= 1'b1;
      for (k = 0; k < 8 && po.clk_en !== 1'b1; k++) @(negedge clk);
      c1(po.clk_en, 1'b1, "no wake on line");
      for (k = 0; k < 3; k++) begin
         apb(1'b1, PARALLEL_CFG_OFS, 32'h00000002);
         repeat (3) @(negedge clk);
         c1(po.force_idle, 1'b1, "not forced idle");
         if (k == 0) apb(1'b1, PARALLEL_CFG_OFS, 32'h0);
         if (k == 1) apb(1'b1, PARALLEL_CFG_OFS, 32'h00000008);
         if (k == 2) @(posedge clk) hrst <= 1'b1;
         repeat (6) @(posedge clk);
         hrst <= 1'b0;
         repeat (6) @(negedge clk);
         c1(po.force_idle, 1'b0, "direct not left");
      end
      rd(PARALLEL_CFG_OFS, 32'h0, 32'h0000000b);
   endtask

   // Hang guard, far beyond the less than one thousand cycles of the tests
   initial begin
      #200000;
      mismatches++;
      close_out;
   end

   // Inputs at time zero, reset, then the scenarios
   initial begin
      nrst = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
      pwdata = 32'h0; hrst = 1'b0; pline = 1'b0; sline = 2'h3;
      fi = '0;
      fi.floppy_main_status_reg = FDC_IDLE_MSR;
      fi.head_unload_time_expired = 1'b1;
      sa = '0;
      sa.transmitter_empty_flag = 1'b1;
      sb = sa;
      pi = '0;
      pi.sm_idle = 1'b1;
      mismatches = 0;
      n_checks = 0;
      repeat (8) @(posedge clk);
      nrst <= 1'b1;
      t_regs;
      t_fdc_auto;
      t_fdc_dir;
      t_ser;
      t_par;
      close_out;
   end
endmodule
